/* File: verilog/dcff_fifo.sv */
// Overview of operation
// [R01] Near-full rises after write reaching threshold
// [R02] Full rises cycle after final location written
// [R03] Write while full dropped, overflow next
// [R04] Read still served when write rejected
// [R05] Simultaneous read and write both succeed
// [R06] Near-full falls after reads exceed threshold
// [R07] No read request holds read data
// [R08] Crossing mode tolerates any clock relation
// [R09] Flags assert immediately, deassert after crossing
// [R10] Request mode: data follows read request
// [R11] Request mode: first write leaves output
// [R12] Read advances output only when nonempty
// [R13] Acknowledge mode: first word falls through
// [R14] Read acknowledges shown word, then advances
// [R15] Empty after reset and last read
// [R16] Output register adds one entry
// [R17] Crossing: empty falls two-three cycles later
// [R18] Crossing: near-empty follows in two-three cycles
// [R19] Read while empty errors, output kept
// [R20] Acknowledge read replaces shown word
// [R21] Shared clock: flags exact, no latency
// [R22] Fall-through unsupported with shared clock
// [R23] Idle cycles change nothing
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dcff_fifo
  import dcff_pkg::*;
(
  input  wire logic                  pclk,     // APB and FIFO clock
  input  wire logic                  presetn,  // Async reset, active low
  input  wire logic                  clk_en,   // Freezes all state when low
  input  wire logic [APB_AW-1:0]     paddr,    // APB address
  input  wire logic                  psel,     // APB select
  input  wire logic                  penable,  // APB access phase
  input  wire logic                  pwrite,   // APB direction
  input  wire logic [31:0]           pwdata,   // APB write data
  output var  logic [31:0]           prdata,   // APB read data
  output var  logic                  pready,   // APB ready
  output var  logic                  pslverr,  // APB error on unmapped address
  input  wire logic                  wr_en,    // Write request
  input  wire dcff_pkg::dcff_word_t  wr_data,  // Write data
  input  wire logic                  rd_en,    // Read request / acknowledge
  output var  dcff_pkg::dcff_word_t  rd_data,  // Read data
  output var  dcff_pkg::dcff_flags_s flags     // Status and error flags
);
  import dcff_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic reg_known(input logic [APB_AW-1:0] a);
    return (a == CTRL_OFS) || (a == THRESH_OFS) || (a == STATUS_OFS) || (a == ERR_OFS);
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  dcff_word_t       mem [DEPTH];
  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] wptr_nxt;
  logic [PTR_W-1:0] rptr_r;
  logic [PTR_W-1:0] rptr_nxt;
  logic [PTR_W-1:0] wgray_r;
  logic [PTR_W-1:0] rgray_r;
  logic [PTR_W-1:0] wsync1_r;
  logic [PTR_W-1:0] wsync2_r;
  logic [PTR_W-1:0] rsync1_r;
  logic [PTR_W-1:0] rsync2_r;
  logic [PTR_W-1:0] wptr_seen;
  logic [PTR_W-1:0] rptr_seen;
  logic [PTR_W-1:0] wused;
  logic [PTR_W-1:0] avail;
  logic [PTR_W-1:0] rstore_nxt;
  logic [LVL_W-1:0] rlevel_nxt;
  logic [LVL_W-1:0] rlevel_r;
  logic [LVL_W-1:0] wfree;
  logic [PTR_W-1:0] wused_r;
  dcff_out_e        out_st_r;
  dcff_out_e        out_st_nxt;
  dcff_word_t       rd_data_r;
  logic             full_r;
  logic             afull_r;
  logic             empty_r;
  logic             aempty_r;
  logic             wr_err_r;
  logic             rd_err_r;
  logic             wr_ok;
  logic             rd_ok;
  logic             pop;
  logic             sync_mode_r;
  logic             fwft_r;
  logic             fwft_eff;
  logic [LVL_W-1:0] afull_ofs_r;
  logic [LVL_W-1:0] aempty_ofs_r;
  logic [1:0]       err_sticky_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic             apb_setup;
  logic             apb_wr;
  logic [31:0]      rd_mux;

  // ---------------------------------------------------------------
  // Mode selection
  // ---------------------------------------------------------------
  // Fall-through only exists with the crossing path; a shared clock forces request mode
  assign fwft_eff = fwft_r & ~sync_mode_r; // [R22]

  // Shared clock sees the partner pointer directly; crossing mode sees it through two flops
  assign wptr_seen = sync_mode_r ? wptr_nxt : gray2bin(wsync2_r); // [R21] [R09] [R08]
  assign rptr_seen = sync_mode_r ? rptr_nxt : gray2bin(rsync2_r); // [R21] [R09] [R08]

  // ---------------------------------------------------------------
  // Write side
  // ---------------------------------------------------------------
  assign wr_ok    = wr_en & ~full_r; // [R03] [R04]
  assign wptr_nxt = wptr_r + {{(PTR_W-1){1'b0}}, wr_ok};
  assign wused    = wptr_nxt - rptr_seen;
  assign wfree    = DEPTH_LVL - {1'b0, wused};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_r  <= '0;
      wgray_r <= '0;
    end
    else if (clk_en)
    begin
      wptr_r  <= wptr_nxt; // [R23]
      wgray_r <= bin2gray(wptr_nxt);
    end
  end

  always_ff @(posedge pclk)
  begin
    if (clk_en && wr_ok)
    begin
      mem[wptr_r[ADDR_W-1:0]] <= wr_data; // [R05]
    end
  end

  // Full and near-full rise from the local pointer, so assertion never waits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_r   <= 1'b0;
      afull_r  <= 1'b0;
      wr_err_r <= 1'b0;
      wused_r  <= '0;
    end
    else if (clk_en)
    begin
      full_r   <= (wused == DEPTH_PTR);   // [R02] [R09]
      afull_r  <= (wfree <= afull_ofs_r); // [R01] [R06]
      wr_err_r <= wr_en & full_r;         // [R03] [R04]
      wused_r  <= wused;
    end
  end

  // ---------------------------------------------------------------
  // Pointer crossing
  // ---------------------------------------------------------------
  // Gray pointers change one bit per step, so a torn sample is off by at most one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wsync1_r <= '0;
      wsync2_r <= '0;
      rsync1_r <= '0;
      rsync2_r <= '0;
    end
    else if (clk_en)
    begin
      wsync1_r <= wgray_r;  // [R08]
      wsync2_r <= wsync1_r; // [R17] [R18]
      rsync1_r <= rgray_r;
      rsync2_r <= rsync1_r;
    end
  end

  // ---------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------
  assign avail = wptr_seen - rptr_r;

  always_comb
  begin
    rd_ok      = 1'b0;
    pop        = 1'b0;
    out_st_nxt = out_st_r;
    if (fwft_eff)
    begin
      case (out_st_r)
        OUT_EMPTY:
        begin
          pop = (avail != '0); // [R13] [R17]
        end
        OUT_HELD:
        begin
          rd_ok = rd_en;                         // [R14]
          pop   = rd_en & (avail != '0);         // [R14] [R20]
        end
        default:
        begin
          pop = 1'b0;
        end
      endcase
      if (pop)
      begin
        out_st_nxt = OUT_HELD;
      end
      else if (rd_ok)
      begin
        out_st_nxt = OUT_EMPTY; // [R15]
      end
    end
    else
    begin
      rd_ok      = rd_en & ~empty_r; // [R12] [R19]
      pop        = rd_ok;            // [R10] [R11]
      out_st_nxt = OUT_EMPTY;
    end
  end

  assign rptr_nxt   = rptr_r + {{(PTR_W-1){1'b0}}, pop};
  assign rstore_nxt = wptr_seen - rptr_nxt;
  // The output register counts as an entry in fall-through mode
  assign rlevel_nxt = {1'b0, rstore_nxt} + {{(LVL_W-1){1'b0}}, (fwft_eff && out_st_nxt == OUT_HELD)}; // [R16]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rptr_r   <= '0;
      rgray_r  <= '0;
      out_st_r <= OUT_EMPTY;
    end
    else if (clk_en)
    begin
      rptr_r   <= rptr_nxt; // [R23]
      rgray_r  <= bin2gray(rptr_nxt);
      out_st_r <= out_st_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_data_r <= '0;
    end
    else if (clk_en && pop)
    begin
      rd_data_r <= mem[rptr_r[ADDR_W-1:0]]; // [R10] [R05] [R07] [R19]
    end
  end

  // Empty and near-empty rise from the local pointer; in crossing mode they only fall once the write pointer crosses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      empty_r  <= 1'b1; // [R15]
      aempty_r <= 1'b1;
      rd_err_r <= 1'b0;
      rlevel_r <= '0;
    end
    else if (clk_en)
    begin
      empty_r  <= fwft_eff ? (out_st_nxt == OUT_EMPTY) : (rstore_nxt == '0); // [R15] [R11] [R17] [R09]
      aempty_r <= (rlevel_nxt <= aempty_ofs_r); // [R18]
      rd_err_r <= rd_en & ~rd_ok;               // [R19]
      rlevel_r <= rlevel_nxt;
    end
  end

  assign rd_data             = rd_data_r;
  assign flags.full          = full_r;
  assign flags.almost_full   = afull_r;
  assign flags.empty         = empty_r;
  assign flags.almost_empty  = aempty_r;
  assign flags.wr_err        = wr_err_r;
  assign flags.rd_err        = rd_err_r;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Read data is captured in the setup cycle so the access phase waits only while clk_en is low
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & clk_en;
  assign pready    = clk_en;
  assign prdata    = prdata_r;
  assign pslverr   = pslverr_r;

  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      CTRL_OFS:
      begin
        rd_mux[CTRL_SYNC_BIT] = sync_mode_r;
        rd_mux[CTRL_FWFT_BIT] = fwft_r;
      end
      THRESH_OFS:
      begin
        rd_mux[THR_AFULL_LSB +: LVL_W]  = afull_ofs_r;
        rd_mux[THR_AEMPTY_LSB +: LVL_W] = aempty_ofs_r;
      end
      STATUS_OFS:
      begin
        rd_mux[ST_EMPTY_BIT]           = empty_r;
        rd_mux[ST_AEMPTY_BIT]          = aempty_r;
        rd_mux[ST_FULL_BIT]            = full_r;
        rd_mux[ST_AFULL_BIT]           = afull_r;
        rd_mux[ST_RLVL_LSB +: LVL_W]   = rlevel_r;
        rd_mux[ST_WLVL_LSB +: PTR_W]   = wused_r;
      end
      ERR_OFS:
      begin
        rd_mux[ERR_WR_BIT] = err_sticky_r[ERR_WR_BIT];
        rd_mux[ERR_RD_BIT] = err_sticky_r[ERR_RD_BIT];
      end
      default:
      begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else if (clk_en && apb_setup)
    begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~reg_known(paddr);
    end
  end

  // Changing mode with words stored scrambles the flags; reconfigure only while idle and empty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_mode_r  <= SYNC_RST;
      fwft_r       <= FWFT_RST;
      afull_ofs_r  <= AFULL_OFS_RST;
      aempty_ofs_r <= AEMPTY_OFS_RST;
    end
    else if (apb_wr && paddr == CTRL_OFS)
    begin
      sync_mode_r <= pwdata[CTRL_SYNC_BIT];
      fwft_r      <= pwdata[CTRL_FWFT_BIT];
    end
    else if (apb_wr && paddr == THRESH_OFS)
    begin
      afull_ofs_r  <= pwdata[THR_AFULL_LSB +: LVL_W];
      aempty_ofs_r <= pwdata[THR_AEMPTY_LSB +: LVL_W];
    end
  end

  // Sticky error copies: a new error in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_sticky_r <= '0;
    end
    else if (clk_en)
    begin
      err_sticky_r[ERR_WR_BIT] <= (err_sticky_r[ERR_WR_BIT] & ~(apb_wr && paddr == ERR_OFS && pwdata[ERR_WR_BIT]))
                                  | (wr_en & full_r); // [R03]
      err_sticky_r[ERR_RD_BIT] <= (err_sticky_r[ERR_RD_BIT] & ~(apb_wr && paddr == ERR_OFS && pwdata[ERR_RD_BIT]))
                                  | (rd_en & ~rd_ok); // [R19]
    end
  end

endmodule
`default_nettype wire

/* File: verilog/dcff_pkg.sv */
`default_nettype none
package dcff_pkg;

  // ---------------------------------------------------------------
  // Storage geometry
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int DEPTH  = 16;
  localparam int PTR_W  = ADDR_W + 1;
  localparam int LVL_W  = PTR_W + 1;

  localparam logic [PTR_W-1:0] DEPTH_PTR = 5'h10;
  localparam logic [LVL_W-1:0] DEPTH_LVL = 6'h10;

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int APB_AW = 8;

  localparam logic [APB_AW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [APB_AW-1:0] THRESH_OFS = 8'h04;
  localparam logic [APB_AW-1:0] STATUS_OFS = 8'h08;
  localparam logic [APB_AW-1:0] ERR_OFS    = 8'h0c;

  // CTRL fields
  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_FWFT_BIT = 1;
  // THRESH fields
  localparam int THR_AFULL_LSB  = 0;
  localparam int THR_AEMPTY_LSB = 8;
  // STATUS fields
  localparam int ST_EMPTY_BIT  = 0;
  localparam int ST_AEMPTY_BIT = 1;
  localparam int ST_FULL_BIT   = 2;
  localparam int ST_AFULL_BIT  = 3;
  localparam int ST_RLVL_LSB   = 8;
  localparam int ST_WLVL_LSB   = 16;
  // ERR fields (write one to clear)
  localparam int ERR_WR_BIT = 0;
  localparam int ERR_RD_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic             SYNC_RST       = 1'b1;
  localparam logic             FWFT_RST       = 1'b0;
  localparam logic [LVL_W-1:0] AFULL_OFS_RST  = 6'h03;
  localparam logic [LVL_W-1:0] AEMPTY_OFS_RST = 6'h03;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic
  {
    OUT_EMPTY = 1'b0,
    OUT_HELD  = 1'b1
  } dcff_out_e;

  typedef struct packed
  {
    logic full;
    logic almost_full;
    logic empty;
    logic almost_empty;
    logic wr_err;
    logic rd_err;
  } dcff_flags_s;

  typedef logic [DATA_W-1:0] dcff_word_t;

endpackage
`default_nettype wire

/* File: verif/dcff_fifo_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dcff_fifo_chk
  import dcff_pkg::*;
(
  input wire logic                  pclk,     // Clock
  input wire logic                  presetn,  // Reset, active low
  input wire logic                  clk_en,   // Clock enable
  input wire logic [APB_AW-1:0]     paddr,    // APB address
  input wire logic                  psel,     // APB select
  input wire logic                  penable,  // APB access phase
  input wire logic                  pwrite,   // APB direction
  input wire logic [31:0]           pwdata,   // APB write data
  input wire logic                  wr_en,    // Write request
  input wire logic                  rd_en,    // Read request
  input wire dcff_pkg::dcff_word_t  rd_data,  // Read data
  input wire dcff_pkg::dcff_flags_s flags     // Status flags
);
  import dcff_pkg::*;
  logic             sync_r;
  logic             fwft_r;
  logic [LVL_W-1:0] thr_r;
  logic [LVL_W-1:0] athr_r;
  logic [LVL_W-1:0] lvl_r;
  logic             wr_ok;
  logic             rd_ok;
  logic             cfg_wr;
  logic             ff_md;

  assign wr_ok  = clk_en && wr_en && !flags.full;
  assign rd_ok  = clk_en && rd_en && !flags.empty;
  assign cfg_wr = clk_en && psel && penable && pwrite;
  assign ff_md  = fwft_r && !sync_r;

  // Shadow of the mode bits, so mode-specific checks stay quiet elsewhere
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync_r <= SYNC_RST;
      fwft_r <= FWFT_RST;
      thr_r  <= AFULL_OFS_RST;
      athr_r <= AEMPTY_OFS_RST;
    end
    else if (cfg_wr && paddr == CTRL_OFS)
    begin
      sync_r <= pwdata[CTRL_SYNC_BIT];
      fwft_r <= pwdata[CTRL_FWFT_BIT];
    end
    else if (cfg_wr && paddr == THRESH_OFS)
    begin
      thr_r  <= pwdata[THR_AFULL_LSB +: LVL_W];
      athr_r <= pwdata[THR_AEMPTY_LSB +: LVL_W];
    end

  // Words held, output register included
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      lvl_r <= '0;
    else
      lvl_r <= lvl_r + LVL_W'(wr_ok) - LVL_W'(rd_ok);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wr_overflow: assert property (clk_en && wr_en && flags.full |=> flags.wr_err)
    else $error("overflow not flagged");
  a_rd_underflow: assert property (clk_en && rd_en && flags.empty |=> flags.rd_err)
    else $error("underflow not flagged");
  a_err_cause: assert property (flags.wr_err || flags.rd_err |->
    $past(wr_en && flags.full) || $past(rd_en && flags.empty))
    else $error("error flag without cause");
  a_rd_hold: assert property (!ff_md && !rd_ok |=> $stable(rd_data))
    else $error("read data moved without read");
  a_full_exact: assert property (sync_r && $past(sync_r, 4) |-> flags.full == (lvl_r == DEPTH_LVL))
    else $error("full flag wrong");
  a_empty_exact: assert property (sync_r && $past(sync_r, 4) |-> flags.empty == (lvl_r == 6'h00))
    else $error("empty flag wrong");
  a_afull_exact: assert property (sync_r && $past(sync_r, 4) |->
    flags.almost_full == (DEPTH_LVL - lvl_r <= thr_r))
    else $error("near-full flag wrong");
  a_aempty_exact: assert property (sync_r && $past(sync_r, 4) |->
    flags.almost_empty == (lvl_r <= athr_r))
    else $error("near-empty flag wrong");
  a_full_set: assert property (!ff_md && wr_ok && !rd_ok && lvl_r == DEPTH_LVL - 6'h01 |=> flags.full)
    else $error("full not raised at once");
  a_empty_set: assert property (rd_ok && !wr_ok && lvl_r == 6'h01 |=> flags.empty)
    else $error("empty not raised at once");
  a_empty_fall: assert property (!sync_r && wr_ok && lvl_r == 6'h00 |-> ##[3:4] !flags.empty)
    else $error("empty did not fall in time");
  a_idle_quiet: assert property (sync_r && !wr_en && !rd_en && !cfg_wr |=>
    $stable({flags.full, flags.almost_full, flags.empty}) && !flags.wr_err && !flags.rd_err)
    else $error("idle cycle changed state");
endmodule

bind dcff_fifo dcff_fifo_chk u_chk
(
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .flags(flags)
);
`default_nettype wire

/* File: verif/dcff_user_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcff_user_model
  import dcff_pkg::*;
(
  input  wire logic                 pclk,     // Clock
  input  wire logic                 presetn,  // Reset, active low
  input  wire logic                 wr_go,    // Keep writing
  input  wire logic                 rd_go,    // Keep reading
  input  wire logic                 slow,     // Read every other cycle
  input  wire dcff_pkg::dcff_word_t seed,     // Next word to write
  output var  logic                 wr_en,    // Write request
  output var  dcff_pkg::dcff_word_t wr_data,  // Write data
  output var  logic                 rd_en     // Read request or acknowledge
);
  import dcff_pkg::*;
  logic ph_r;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph_r    <= 1'b0;
      wr_en   <= 1'b0;
      wr_data <= '0;
      rd_en   <= 1'b0;
    end
    else
    begin
      ph_r    <= ~ph_r;
      wr_en   <= wr_go;
      // Idle data toggles so a stale word never looks valid
      wr_data <= wr_go ? seed : ~wr_data;
      rd_en   <= rd_go && (!slow || ph_r);
    end
endmodule
`default_nettype wire

/* File: verif/dcff_fifo_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dcff_fifo_tb_top;
  import dcff_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              wr_go;
  logic              rd_go;
  logic              slow;
  logic              wr_en;
  logic              rd_en;
  logic              fwft_on;
  logic              pend = 1'b0;
  logic [31:0]       ar;
  logic              ae;
  dcff_word_t        wr_data;
  dcff_word_t        rd_data;
  dcff_word_t        seed = 32'h2a;
  dcff_flags_s       flags;
  dcff_word_t        exp_q[$];
  int                bad_count;
  int                num_checks;

  dcff_fifo dut
  (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .flags(flags)
  );

  dcff_user_model u_user
  (
    .pclk(pclk), .presetn(presetn), .wr_go(wr_go), .rd_go(rd_go), .slow(slow), .seed(seed),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en)
  );

  function automatic dcff_word_t xs(input dcff_word_t x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic fail(input string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic check(input dcff_word_t got);
    dcff_word_t e;
    num_checks++;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
    if (got !== e)
      fail($sformatf("read data %h expected %h", got, e));
  endtask

  // ---------------------------------------------
  // APB master: setup, access until pready
  // ---------------------------------------------
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    ar = prdata;
    ae = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      fail("bus hang");
      report_and_stop;
    end
  endtask

  task automatic apb_chk(input logic [APB_AW-1:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    num_checks++;
    if (ar !== e || ae !== ee)
      fail($sformatf("reg %h read %h err %b", a, ar, ae));
  endtask

  task automatic wait_flag(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (flags[b] !== v && n < 300);
    if (n >= 300)
    begin
      fail("flag wait timed out");
      report_and_stop;
    end
  endtask

  // Reads until empty, then four more cycles before reads stop
  task automatic drain;
    rd_go <= 1'b1;
    wait_flag(3, 1'b1);
    repeat (4) @(posedge pclk);
    rd_go <= 1'b0;
  endtask

  // Result checker: takes the oldest note whenever a read result appears
  always @(posedge pclk)
    if (presetn)
    begin
      if (pend)
        check(rd_data);
      pend = rd_en && !flags.empty && !fwft_on;
      if (rd_en && !flags.empty && fwft_on)
        check(rd_data);
      if (wr_en && !flags.full)
        exp_q.push_back(wr_data);
    end

  always @(posedge pclk)
    seed <= xs(seed);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    fail("run timed out");
    report_and_stop;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, wr_go, rd_go, slow, fwft_on} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb_chk(CTRL_OFS, 32'h1, 1'b0);
    apb_chk(THRESH_OFS, 32'h303, 1'b0);
    apb_chk(STATUS_OFS, 32'h3, 1'b0);
    apb_chk(8'h10, 32'h0, 1'b1);
    // Thresholds moved off reset values while empty, so the compares see new limits
    apb(1'b1, THRESH_OFS, 32'h405);
    apb_chk(THRESH_OFS, 32'h405, 1'b0);
    // Shared clock: read on empty with a write, fill past full, reads at full
    @(posedge pclk);
    wr_go <= 1'b1;
    rd_go <= 1'b1;
    @(posedge pclk);
    rd_go <= 1'b0;
    wait_flag(5, 1'b1);
    @(posedge pclk);
    rd_go <= 1'b1;
    repeat (2) @(posedge pclk);
    wr_go <= 1'b0;
    slow  <= 1'b1;
    drain();
    apb_chk(ERR_OFS, 32'h3, 1'b0);
    apb(1'b1, ERR_OFS, 32'h3);
    apb_chk(ERR_OFS, 32'h0, 1'b0);
    // Crossing, request mode
    apb(1'b1, CTRL_OFS, 32'h0);
    wr_go <= 1'b1;
    repeat (5) @(posedge pclk);
    wr_go <= 1'b0;
    slow  <= 1'b0;
    wait_flag(3, 1'b0);
    drain();
    // Crossing, fall-through: one extra entry
    fwft_on = 1'b1;
    apb(1'b1, CTRL_OFS, 32'h2);
    wr_go <= 1'b1;
    repeat (24) @(posedge pclk);
    wr_go <= 1'b0;
    repeat (4) @(posedge pclk);
    num_checks++;
    if (exp_q.size() != 17)
      fail($sformatf("held %0d words", exp_q.size()));
    slow <= 1'b1;
    drain();
    num_checks++;
    if (exp_q.size() != 0)
      fail("words never delivered");
    report_and_stop;
  end
endmodule
`default_nettype wire
